/* pkg/mmt_consts.svh */
// register offsets, field positions, reset values and timing for the mode timer unit
`ifndef MMT_CONSTS_SVH
`define MMT_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define MMT_OFF_RESET_CTRL 8'h00
`define MMT_OFF_CAPTURE_CTRL 8'h04
`define MMT_OFF_CAPTURE_VALUE 8'h08
`define MMT_OFF_COMMUTATION_COMPARE 8'h0c
`define MMT_OFF_SAMPLE_START_COMPARE 8'h10
`define MMT_OFF_OVERFLOW_COMPARE 8'h14

// ----------------------------------------------------------------------
// timer_reset_control fields
// ----------------------------------------------------------------------
`define MMT_RC_RUN_EN 0
`define MMT_RC_CLR_DETECT 1
`define MMT_RC_SOFT_CLEAR 2
`define MMT_RC_CLR_OVERLOAD 3
`define MMT_RC_CLR_THIRD 4
`define MMT_RC_CLK_SEL_LO 5
`define MMT_RC_CLK_SEL_HI 7

// ----------------------------------------------------------------------
// timer_capture_control fields
// ----------------------------------------------------------------------
`define MMT_CC_CAP_DETECT 1
`define MMT_CC_SOFT_CAPTURE 2
`define MMT_CC_CAP_OVERLOAD 3
`define MMT_CC_OVERFLOW 5
`define MMT_CC_DEBUG_OUT 7

// ----------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------
`define MMT_RST_CTRL 8'h00
`define MMT_RST_WORD 16'h0000
`define MMT_COUNT_MAX 16'hffff

// ----------------------------------------------------------------------
// clock select codes, divide by 2^3 .. 2^7 of clk
// ----------------------------------------------------------------------
`define MMT_SEL_DIV8 3'h0
`define MMT_SEL_DIV16 3'h2
`define MMT_SEL_DIV32 3'h4
`define MMT_SEL_DIV64 3'h6
`define MMT_SEL_DIV128 3'h1
`define MMT_PRESCALE_W 7

`endif

/* pkg/mmt_pkg.sv */
// types of the mode timer unit
package mmt_pkg;

  typedef struct packed {
    logic [2:0] count_clock_select;
    logic clear_on_third_timer_en;
    logic clear_on_overload_en;
    logic clear_on_detect_en;
    logic count_run_en;
  } mmt_reset_ctrl_t;

  typedef struct packed {
    logic debug_irq_out_en;
    logic count_overflow_flag;
    logic capture_on_overload_en;
    logic capture_on_detect_en;
  } mmt_capture_ctrl_t;

  typedef struct packed {
    logic [6:0] prescale;
    logic overload_prev;
    mmt_reset_ctrl_t rctl;
    mmt_capture_ctrl_t cctl;
    logic [15:0] count;
    logic [15:0] capture;
    logic [15:0] commutation_compare;
    logic [15:0] sample_start_compare;
    logic [15:0] overflow_compare;
    logic [2:0] armed;
    logic [2:0] irq;
    logic [2:0] debug;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } mmt_state_t;

endpackage : mmt_pkg

/* src/mmt_timer.sv */
// mode timer with capture, three compare timers and AHB-Lite register slave
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "mmt_consts.svh"

module mmt_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic detect_irq,
  input wire logic overload_trip,
  output logic [2:0] cmp_irq,
  output logic [2:0] debug_irq_out
);

  mmt_pkg::mmt_state_t st_r;
  mmt_pkg::mmt_state_t st_nxt;

  logic addr_ok;
  logic rd_take;
  logic wr_take;
  logic tick;
  logic overload_rise;
  logic clear_evt;
  logic capture_evt;
  logic soft_clear;
  logic soft_capture;
  logic running;
  logic run_drop;
  logic [2:0] fire;
  logic [2:0] rearm;
  logic [15:0] wd;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  assign addr_ok = hsel && hready && htrans[1];
  assign rd_take = addr_ok && !hwrite;
  assign wr_take = addr_ok && hwrite;
  assign wd = hwdata[15:0];
  assign soft_clear = st_r.wr_pend && (st_r.wr_addr == `MMT_OFF_RESET_CTRL) &&
                      hwdata[`MMT_RC_SOFT_CLEAR];
  assign soft_capture = st_r.wr_pend && (st_r.wr_addr == `MMT_OFF_CAPTURE_CTRL) &&
                        hwdata[`MMT_CC_SOFT_CAPTURE];
  assign rearm[0] = st_r.wr_pend && (st_r.wr_addr == `MMT_OFF_COMMUTATION_COMPARE);
  assign rearm[1] = st_r.wr_pend && (st_r.wr_addr == `MMT_OFF_SAMPLE_START_COMPARE);
  assign rearm[2] = st_r.wr_pend && (st_r.wr_addr == `MMT_OFF_OVERFLOW_COMPARE);

  // ----------------------------------------------------------------------
  // prescaler tick select
  // ----------------------------------------------------------------------
  always_comb begin
    case (st_r.rctl.count_clock_select)
      `MMT_SEL_DIV8: tick = &st_r.prescale[2:0];
      `MMT_SEL_DIV16: tick = &st_r.prescale[3:0];
      `MMT_SEL_DIV32: tick = &st_r.prescale[4:0];
      `MMT_SEL_DIV64: tick = &st_r.prescale[5:0];
      `MMT_SEL_DIV128: tick = &st_r.prescale[6:0];
      default: tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // trigger merge
  // ----------------------------------------------------------------------
  assign running = st_r.rctl.count_run_en;
  // compares loaded while stopped stay armed; a falling run bit or a clear event drops them
  assign run_drop = running && st_r.wr_pend && (st_r.wr_addr == `MMT_OFF_RESET_CTRL) &&
                    !hwdata[`MMT_RC_RUN_EN];
  assign overload_rise = overload_trip && !st_r.overload_prev;
  assign clear_evt = soft_clear ||
                     (detect_irq && st_r.rctl.clear_on_detect_en) ||
                     (overload_rise && st_r.rctl.clear_on_overload_en) ||
                     (st_r.irq[2] && st_r.rctl.clear_on_third_timer_en);
  assign capture_evt = soft_capture ||
                       (detect_irq && st_r.cctl.capture_on_detect_en) ||
                       (overload_rise && st_r.cctl.capture_on_overload_en);

  // compares only while running and armed
  assign fire[0] = running && st_r.armed[0] && (st_r.count >= st_r.commutation_compare);
  assign fire[1] = running && st_r.armed[1] && (st_r.count == st_r.sample_start_compare);
  assign fire[2] = running && st_r.armed[2] && (st_r.count == st_r.overflow_compare);

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.prescale = st_r.prescale + 7'h01;
    st_nxt.overload_prev = overload_trip;
    st_nxt.irq = fire;
    st_nxt.debug = st_r.cctl.debug_irq_out_en ? fire : 3'h0;
    // a fired or cleared compare stays disarmed until rewritten
    st_nxt.armed = st_r.armed & ~fire;
    if (clear_evt || run_drop) begin
      st_nxt.armed = 3'h0;
    end
    st_nxt.armed = st_nxt.armed | rearm;
    if (clear_evt) begin
      st_nxt.count = `MMT_RST_WORD;
      st_nxt.cctl.count_overflow_flag = 1'b0;
    end else if (running && tick && st_r.count != `MMT_COUNT_MAX) begin
      st_nxt.count = st_r.count + 16'h0001;
      if (st_r.count == `MMT_COUNT_MAX - 16'h0001) begin
        st_nxt.cctl.count_overflow_flag = 1'b1;
      end
    end
    if (capture_evt) begin
      st_nxt.capture = st_r.count;
    end
    // write data phase
    st_nxt.wr_pend = wr_take;
    st_nxt.wr_addr = haddr;
    if (st_r.wr_pend) begin
      if (st_r.wr_addr == `MMT_OFF_RESET_CTRL) begin
        st_nxt.rctl.count_clock_select = hwdata[`MMT_RC_CLK_SEL_HI:`MMT_RC_CLK_SEL_LO];
        st_nxt.rctl.clear_on_third_timer_en = hwdata[`MMT_RC_CLR_THIRD];
        st_nxt.rctl.clear_on_overload_en = hwdata[`MMT_RC_CLR_OVERLOAD];
        st_nxt.rctl.clear_on_detect_en = hwdata[`MMT_RC_CLR_DETECT];
        st_nxt.rctl.count_run_en = hwdata[`MMT_RC_RUN_EN];
      end else if (st_r.wr_addr == `MMT_OFF_CAPTURE_CTRL) begin
        st_nxt.cctl.debug_irq_out_en = hwdata[`MMT_CC_DEBUG_OUT];
        st_nxt.cctl.capture_on_overload_en = hwdata[`MMT_CC_CAP_OVERLOAD];
        st_nxt.cctl.capture_on_detect_en = hwdata[`MMT_CC_CAP_DETECT];
      end else if (st_r.wr_addr == `MMT_OFF_COMMUTATION_COMPARE) begin
        st_nxt.commutation_compare = wd;
      end else if (st_r.wr_addr == `MMT_OFF_SAMPLE_START_COMPARE) begin
        st_nxt.sample_start_compare = wd;
      end else if (st_r.wr_addr == `MMT_OFF_OVERFLOW_COMPARE) begin
        st_nxt.overflow_compare = wd;
      end
    end
    // read data registered for the following data phase
    st_nxt.rdata = 32'h0000_0000;
    if (rd_take) begin
      if (haddr == `MMT_OFF_RESET_CTRL) begin
        st_nxt.rdata = {24'h00_0000, st_r.rctl.count_clock_select,
                        st_r.rctl.clear_on_third_timer_en, st_r.rctl.clear_on_overload_en,
                        1'b0, st_r.rctl.clear_on_detect_en, st_r.rctl.count_run_en};
      end else if (haddr == `MMT_OFF_CAPTURE_CTRL) begin
        st_nxt.rdata = {24'h00_0000, st_r.cctl.debug_irq_out_en, 1'b0,
                        st_r.cctl.count_overflow_flag, 1'b0,
                        st_r.cctl.capture_on_overload_en, 1'b0,
                        st_r.cctl.capture_on_detect_en, 1'b0};
      end else if (haddr == `MMT_OFF_CAPTURE_VALUE) begin
        st_nxt.rdata = {16'h0000, st_r.capture};
      end else if (haddr == `MMT_OFF_COMMUTATION_COMPARE) begin
        st_nxt.rdata = {16'h0000, st_r.commutation_compare};
      end else if (haddr == `MMT_OFF_SAMPLE_START_COMPARE) begin
        st_nxt.rdata = {16'h0000, st_r.sample_start_compare};
      end else if (haddr == `MMT_OFF_OVERFLOW_COMPARE) begin
        st_nxt.rdata = {16'h0000, st_r.overflow_compare};
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata = st_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign cmp_irq = st_r.irq;
  assign debug_irq_out = st_r.debug;

endmodule : mmt_timer

/* test/mmt_sensor_model.sv */
// position detection and overload trip model
`timescale 1ns/1ps
module mmt_sensor_model (
  input wire logic clk,
  output logic detect_irq,
  output logic overload_trip
);
  initial begin
    detect_irq = 1'b0;
    overload_trip = 1'b0;
  end
  task automatic pulse_detect();
    @(posedge clk);
    detect_irq <= 1'b1;
    @(posedge clk);
    detect_irq <= 1'b0;
  endtask : pulse_detect
  task automatic set_trip(input logic lvl);
    @(posedge clk);
    overload_trip <= lvl;
  endtask : set_trip
endmodule : mmt_sensor_model

/* test/mmt_timer_asserts.sv */
// port checker of the mode timer unit
`timescale 1ns/1ps
module mmt_timer_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [2:0] cmp_irq,
  input wire logic [2:0] debug_irq_out
);
  logic rd_r, wr_r, run_r, dbg_r;
  logic [7:0] a_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // shadow of run and debug bits from bus writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {rd_r, wr_r, run_r, dbg_r, a_r} <= 12'h000;
    end else begin
      rd_r <= hsel && hready && htrans[1] && !hwrite;
      wr_r <= hsel && hready && htrans[1] && hwrite;
      a_r <= haddr;
      if (wr_r && a_r == 8'h00) run_r <= hwdata[0];
      if (wr_r && a_r == 8'h04) dbg_r <= hwdata[7];
    end
  end
  sequence s_pulse_gone;
    (cmp_irq & $past(cmp_irq)) == 3'h0;
  endsequence
  property p_bus_ok; hreadyout && !hresp; endproperty
  property p_rdata_idle; !rd_r |-> hrdata == 32'h0; endproperty
  property p_upper_zero; rd_r |-> hrdata[31:16] == 16'h0; endproperty
  property p_unmapped; rd_r && a_r > 8'h14 |-> hrdata == 32'h0; endproperty
  property p_one_shot; |cmp_irq && !$past(wr_r) |=> s_pulse_gone; endproperty
  property p_run_only; |cmp_irq |-> $past(run_r); endproperty
  property p_dbg_on; dbg_r && $past(dbg_r) |-> debug_irq_out == cmp_irq; endproperty
  property p_dbg_off; !dbg_r && !$past(dbg_r) |-> debug_irq_out == 3'h0; endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready okay");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_one_shot: assert property (p_one_shot) else $error("compare fired twice");
  a_run_only: assert property (p_run_only) else $error("compare fired while stopped");
  a_dbg_on: assert property (p_dbg_on) else $error("debug pins differ");
  a_dbg_off: assert property (p_dbg_off) else $error("debug pins active");
endmodule : mmt_timer_asserts
bind mmt_timer mmt_timer_asserts u_chk (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .cmp_irq(cmp_irq), .debug_irq_out(debug_irq_out));

/* test/motor_mode_timer_unit_tb.sv */
// self-checking bench of the mode timer unit
`timescale 1ns/1ps
module motor_mode_timer_unit_tb;
  logic clk, rst, hsel, hwrite, hreadyout, hresp, detect_irq, overload_trip;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, v, w;
  logic [2:0] cmp_irq, debug_irq_out;
  logic [2:0] sel [5] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h1};
  int failures, cmp_count, dbg_n;
  int irq_n [3];
  mmt_timer uut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .detect_irq(detect_irq),
    .overload_trip(overload_trip), .cmp_irq(cmp_irq), .debug_irq_out(debug_irq_out));
  mmt_sensor_model u_sen (.clk(clk), .detect_irq(detect_irq), .overload_trip(overload_trip));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) if (cmp_irq[i] === 1'b1) irq_n[i]++;
    if (debug_irq_out !== 3'h0) dbg_n++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask : bus
  task automatic in_range(input int lo, input int hi, input string nm);
    bus(1'b0, 8'h08, 32'h0);
    check({31'h0, v >= lo && v <= hi}, 32'h1, nm);
  endtask : in_range
  task automatic t_regs();
    for (int a = 0; a < 8; a++) begin
      bus(1'b0, 8'(a * 4), 32'h0);
      check(v, 32'h0, "reset value");
    end
    bus(1'b1, 8'h0c, 32'h0000abcd);
    bus(1'b1, 8'h14, 32'hffff5678);
    bus(1'b1, 8'h08, 32'h00001111);
    bus(1'b1, 8'h04, 32'h000000a4);
    bus(1'b0, 8'h0c, 32'h0);
    check(v, 32'h0000abcd, "commutation_compare");
    bus(1'b0, 8'h14, 32'h0);
    check(v, 32'h00005678, "overflow_compare");
    bus(1'b0, 8'h04, 32'h0);
    check(v, 32'h00000080, "capture ctrl");
    in_range(0, 0, "capture ro");
  endtask : t_regs
  task automatic t_count();
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, 8'h00, {24'h0, sel[k], 5'h04});
      bus(1'b1, 8'h00, {24'h0, sel[k], 5'h01});
      repeat (80 << k) @(posedge clk);
      bus(1'b1, 8'h04, 32'h84);
      in_range(9, 11, "count rate");
    end
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h04, 32'h84);
    bus(1'b0, 8'h08, 32'h0);
    w = v;
    repeat (300) @(posedge clk);
    bus(1'b1, 8'h04, 32'h84);
    bus(1'b0, 8'h08, 32'h0);
    check(v, w, "stopped count");
  endtask : t_count
  task automatic t_event(input logic ov);
    bus(1'b1, 8'h04, 32'h0a);
    bus(1'b1, 8'h00, 32'h04);
    bus(1'b1, 8'h00, ov ? 32'h09 : 32'h03);
    repeat (40) @(posedge clk);
    if (ov) u_sen.set_trip(1'b1);
    else u_sen.pulse_detect();
    in_range(4, 6, "event capture");
    bus(1'b1, 8'h04, 32'h0e);
    in_range(0, 1, "event clear");
    u_sen.set_trip(1'b0);
  endtask : t_event
  task automatic t_cmp();
    bus(1'b1, 8'h00, 32'h04);
    bus(1'b1, 8'h0c, 32'h04);
    bus(1'b1, 8'h10, 32'h06);
    bus(1'b1, 8'h14, 32'h08);
    bus(1'b1, 8'h04, 32'h80);
    irq_n = '{0, 0, 0};
    dbg_n = 0;
    bus(1'b1, 8'h00, 32'h11);
    repeat (150) @(posedge clk);
    bus(1'b1, 8'h04, 32'h84);
    in_range(8, 13, "third clear");
    for (int i = 0; i < 3; i++) check(irq_n[i], 1, "irq count");
    bus(1'b1, 8'h0c, 32'h02);
    repeat (4) @(posedge clk);
    check(irq_n[0], 2, "rearm late");
    check(dbg_n, 4, "debug pulses");
  endtask : t_cmp
  task automatic conclude();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  initial begin
    {rst, hsel, hwrite, haddr, htrans, hwdata} = {1'b1, 44'h0};
    {failures, cmp_count} = {32'd0, 32'd0};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_count();
    t_event(1'b0);
    t_event(1'b1);
    t_cmp();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule : motor_mode_timer_unit_tb
